// ### design/pcw_pkg.sv
// shared constants and carrier types for the counter array pwm16 / watchdog block
package pcw_pkg;

  // register byte addresses on the plain register port
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h01;
  localparam logic [7:0] ADDR_CNT_LO = 8'h02;
  localparam logic [7:0] ADDR_CNT_HI = 8'h03;
  localparam logic [7:0] ADDR_MMODE_BASE = 8'h04;
  localparam logic [7:0] ADDR_CMP_BASE = 8'h08;
  localparam int NUM_MODULES = 3;
  localparam int WDOG_MODULE = 2;

  // counter_control_register fields
  localparam int CTRL_CF = 7;
  localparam int CTRL_CR = 6;

  // counter_mode_register fields
  localparam int MD_IDLE = 7;
  localparam int MD_WDOG_ENABLE_BIT = 6;
  localparam int MD_LOCK = 5;
  localparam int MD_CPS_LO = 1;
  localparam int MD_ECF = 0;

  // module_mode_register fields
  localparam int MM_WIDE = 7;
  localparam int MM_CMPEN = 6;
  localparam int MM_MATCH = 3;
  localparam int MM_PWM = 1;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MMODE_RESET = 8'h00;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic WDOG_ENABLE_BIT_RESET = 1'b1;
  localparam logic LOCK_RESET = 1'b0;

  // prescaler divide counts
  localparam logic [3:0] DIV_SLOW = 4'hc;
  localparam logic [1:0] DIV_FAST_MASK = 2'h3;

  // array clock sources selected by clock_select_bits
  typedef enum logic [2:0] {
    CS_DIV12, CS_DIV4, CS_TMR0, CS_EXT_EDGE, CS_SYS, CS_EXT_OSC, CS_RSVD6, CS_RSVD7
  } pcw_clk_src_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcw_bus_req_type;

  typedef struct packed {
    logic tick;
    logic wrap;
    logic [15:0] nxt;
  } pcw_count_type;

endpackage : pcw_pkg

// ### design/pcw_prescaler.sv
// array clock prescaler: one-cycle tick per array clock from the selected source
`timescale 1ns/1ps
module pcw_prescaler import pcw_pkg::*; (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [2:0] sel,
  input wire logic tmr0_ovf,
  input wire logic ext_osc_tick,
  input wire logic ext_clk_pin,
  output logic tick
);

  typedef struct packed {
    logic [3:0] div;
    logic sync1;
    logic sync2;
    logic sync3;
  } pcw_pre_state_type;

  pcw_pre_state_type s_r;
  pcw_pre_state_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.div = (s_r.div == DIV_SLOW - 4'h1) ? 4'h0 : s_r.div + 4'h1;
    s_nxt.sync1 = ext_clk_pin;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // external pin counts on its falling edge, seen only after the two-flop synchroniser
  always_comb begin
    case (pcw_clk_src_type'(sel))
      CS_DIV12: tick = (s_r.div == DIV_SLOW - 4'h1);
      CS_DIV4: tick = (s_r.div[1:0] == DIV_FAST_MASK);
      CS_TMR0: tick = tmr0_ovf;
      CS_EXT_EDGE: tick = s_r.sync3 & ~s_r.sync2;
      CS_SYS: tick = 1'b1;
      CS_EXT_OSC: tick = ext_osc_tick;
      default: tick = 1'b0;
    endcase
  end

endmodule : pcw_prescaler

// ### design/pcw_pwm_unit.sv
// one capture/compare module: compare match, 16-bit pwm output and zero-duty hold
`timescale 1ns/1ps
module pcw_pwm_unit import pcw_pkg::*; (
  input wire logic core_clk,
  input wire logic nrst,
  input pcw_count_type cnt,
  input wire logic [15:0] cmp,
  input wire logic [7:0] mode,
  output logic pin,
  output logic match
);

  typedef struct packed {
    logic pin;
  } pcw_unit_state_type;

  pcw_unit_state_type s_r;
  pcw_unit_state_type s_nxt;
  logic sixteen;
  logic hit;

  assign sixteen = mode[MM_CMPEN] & mode[MM_PWM] & mode[MM_WIDE];
  assign hit = mode[MM_CMPEN] & cnt.tick & (cnt.nxt == cmp);
  assign match = hit & mode[MM_MATCH];
  assign pin = s_r.pin;

  always_comb begin
    s_nxt = s_r;
    if (mode[MM_PWM] && !mode[MM_CMPEN]) begin
      s_nxt.pin = 1'b0;
    end else if (sixteen) begin
      // a match on the wrap cycle wins, so a zero compare word stays high
      if (cnt.tick && cnt.wrap) begin
        s_nxt.pin = 1'b0;
      end
      if (hit) begin
        s_nxt.pin = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  match_high_a: assert property (sixteen && hit |=> pin)
    else $error("output not high after compare match");
  wrap_low_a: assert property (sixteen && cnt.tick && cnt.wrap && !hit |=> !pin)
    else $error("output not low after counter overflow");
  zero_duty_a: assert property (mode[MM_PWM] && !mode[MM_CMPEN] |=> !pin)
    else $error("output not held low with compare disabled");
  match_flag_a: assert property (sixteen && mode[MM_MATCH] && hit |-> match)
    else $error("match event missing in 16-bit pwm");

endmodule : pcw_pwm_unit

// ### design/pcw_array.sv
// counter array core: shared 16-bit counter, control registers, pwm modules, watchdog
//
// What this block does
// - in pwm modes a cleared compare_enable holds the output low
// - 16-bit pwm: output high on compare match, low on counter overflow
// - 16-bit pwm needs compare_enable, pwm_enable and pwm_wide_select together
// - with match_flag_enable, each 16-bit match sets module_event_flag
// - 16-bit overflow, the falling edge, sets counter_overflow_flag
// - low compare byte write clears compare_enable, high byte write sets it
// - compare word zero gives full high, 0xffff the shortest high time
// - module 2 acts as watchdog raising reset when updates come too late
// - watchdog compares module 2 high byte to counter high; low byte is offset
// - after reset watchdog on, clock divided by 12, counter and offset zero
// - watchdog on: counter forced, counter writes, clock, idle, module 2 locked
// - counter_run_bit writes cannot stop it; bit reads only software value
// - watchdog update write loads counter high byte plus offset
// - reset when low byte overflows while update byte equals counter high
// - writing one to module2_event_flag with watchdog on forces reset
// - timeout is 256 times offset plus 256 minus low byte at update
// - enable or lock bit enables watchdog; lock holds until system reset
// - enable is mode bit 6 resetting to one, lock is bit 5 resetting to zero
// - idle_suspend_bit freezes the array while the processor idles
// - overflow flag set on 16-bit wrap, cleared only by software
`timescale 1ns/1ps
module pcw_array import pcw_pkg::*; (
  input wire logic core_clk,
  input wire logic nrst,
  input pcw_bus_req_type bus,
  output logic [7:0] rdata,
  input wire logic cpu_idle,
  input wire logic tmr0_ovf,
  input wire logic ext_osc_tick,
  input wire logic ext_clk_pin,
  output logic [NUM_MODULES-1:0] module_output_pin,
  output logic wdog_reset_req
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [15:0] cnt;
    logic cr;
    logic cf;
    logic [NUM_MODULES-1:0] ccf;
    logic idle;
    logic wdog_enable_bit;
    logic lock;
    logic [2:0] cps;
    logic ecf;
    logic [NUM_MODULES-1:0][7:0] mmode;
    logic [NUM_MODULES-1:0][15:0] cmp;
    logic [7:0] rdata;
    logic wdrst;
  } pcw_state_type;

  pcw_state_type s_r;
  pcw_state_type s_nxt;

  logic tick;
  logic wd_en;
  logic run;
  logic [7:0] upd_calc;
  pcw_count_type cnt_info;
  logic [NUM_MODULES-1:0] match;
  logic [NUM_MODULES-1:0][7:0] mode_eff;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [15:0] put_byte(input logic [15:0] w, input logic hi,
                                           input logic [7:0] d);
    return hi ? {d, w[7:0]} : {w[15:8], d};
  endfunction : put_byte

  // true when addr falls in [base, base+n)
  function automatic logic in_window(input logic [7:0] addr, input logic [7:0] base,
                                     input logic [7:0] n);
    logic [7:0] rel;
    rel = addr - base;
    return (addr >= base) && (rel < n);
  endfunction : in_window

  function automatic logic [1:0] mode_idx(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - ADDR_MMODE_BASE;
    return rel[1:0];
  endfunction : mode_idx

  function automatic logic [1:0] cmp_idx(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - ADDR_CMP_BASE;
    return rel[2:1];
  endfunction : cmp_idx

  ////////////////////////////////////////////////////////////////////////////
  // clocking of the shared counter

  pcw_prescaler u_pre (
    .core_clk(core_clk),
    .nrst(nrst),
    .sel(s_r.cps),
    .tmr0_ovf(tmr0_ovf),
    .ext_osc_tick(ext_osc_tick),
    .ext_clk_pin(ext_clk_pin),
    .tick(tick)
  );

  assign wd_en = s_r.wdog_enable_bit | s_r.lock;
  // the watchdog keeps the counter running whatever software left in the run bit
  assign run = (s_r.cr | wd_en) & ~(s_r.idle & cpu_idle);
  assign cnt_info.tick = tick & run;
  assign cnt_info.wrap = (s_r.cnt == 16'hffff);
  assign cnt_info.nxt = s_r.cnt + 16'h0001;
  assign upd_calc = s_r.cnt[15:8] + s_r.cmp[WDOG_MODULE][7:0];

  ////////////////////////////////////////////////////////////////////////////
  // capture/compare modules

  // module 2 is pinned to software timer behaviour while it guards the system
  always_comb begin
    mode_eff = s_r.mmode;
    if (wd_en) begin
      mode_eff[WDOG_MODULE] = '0;
      mode_eff[WDOG_MODULE][MM_CMPEN] = 1'b1;
      mode_eff[WDOG_MODULE][MM_MATCH] = 1'b1;
    end
  end

  for (genvar i = 0; i < NUM_MODULES; i++) begin : g_unit
    pcw_pwm_unit u_unit (
      .core_clk(core_clk),
      .nrst(nrst),
      .cnt(cnt_info),
      .cmp(s_r.cmp[i]),
      .mode(mode_eff[i]),
      .pin(module_output_pin[i]),
      .match(match[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_nxt = s_r;
    s_nxt.wdrst = 1'b0;
    s_nxt.rdata = 8'h00;

    if (cnt_info.tick) begin
      s_nxt.cnt = cnt_info.nxt;
    end

    // register writes
    if (bus.wr) begin
      if (bus.addr == ADDR_CTRL) begin
        s_nxt.cf = bus.wdata[CTRL_CF];
        s_nxt.cr = bus.wdata[CTRL_CR];
        s_nxt.ccf = bus.wdata[NUM_MODULES-1:0];
        if (wd_en && bus.wdata[WDOG_MODULE]) begin
          s_nxt.wdrst = 1'b1;
        end
      end else if (bus.addr == ADDR_MODE) begin
        s_nxt.wdog_enable_bit = bus.wdata[MD_WDOG_ENABLE_BIT];
        s_nxt.lock = s_r.lock | bus.wdata[MD_LOCK];
        s_nxt.ecf = bus.wdata[MD_ECF];
        if (!wd_en) begin
          s_nxt.idle = bus.wdata[MD_IDLE];
          s_nxt.cps = bus.wdata[MD_CPS_LO +: 3];
        end
      end else if (bus.addr == ADDR_CNT_LO || bus.addr == ADDR_CNT_HI) begin
        if (!wd_en) begin
          s_nxt.cnt = put_byte(s_r.cnt, bus.addr == ADDR_CNT_HI, bus.wdata);
        end
      end else if (in_window(bus.addr, ADDR_MMODE_BASE, 8'(NUM_MODULES))) begin
        if (!(wd_en && mode_idx(bus.addr) == 2'(WDOG_MODULE))) begin
          s_nxt.mmode[mode_idx(bus.addr)] = bus.wdata;
        end
      end else if (in_window(bus.addr, ADDR_CMP_BASE, 8'(2 * NUM_MODULES))) begin
        if (wd_en && cmp_idx(bus.addr) == 2'(WDOG_MODULE) && bus.addr[0]) begin
          // the written value is dropped; the deadline moves from the counter's position
          s_nxt.cmp[WDOG_MODULE][15:8] = upd_calc;
        end else begin
          s_nxt.cmp[cmp_idx(bus.addr)] =
            put_byte(s_r.cmp[cmp_idx(bus.addr)], bus.addr[0], bus.wdata);
        end
        s_nxt.mmode[cmp_idx(bus.addr)][MM_CMPEN] = bus.addr[0];
      end
    end

    // hardware sets come after software clears, so an event in the clear cycle survives
    if (cnt_info.tick && cnt_info.wrap) begin
      s_nxt.cf = 1'b1;
    end
    s_nxt.ccf = s_nxt.ccf | match;

    // deadline: low byte rolls over while the update byte matches the high byte
    if (wd_en && cnt_info.tick && s_r.cnt[7:0] == 8'hff &&
        s_r.cmp[WDOG_MODULE][15:8] == s_r.cnt[15:8]) begin
      s_nxt.wdrst = 1'b1;
    end

    // register reads, data valid only in the following cycle
    if (bus.rd) begin
      if (bus.addr == ADDR_CTRL) begin
        s_nxt.rdata = 8'h00;
        s_nxt.rdata[CTRL_CF] = s_r.cf;
        s_nxt.rdata[CTRL_CR] = s_r.cr;
        s_nxt.rdata[NUM_MODULES-1:0] = s_r.ccf;
      end else if (bus.addr == ADDR_MODE) begin
        s_nxt.rdata = {s_r.idle, s_r.wdog_enable_bit, s_r.lock, 1'b0, s_r.cps, s_r.ecf};
      end else if (bus.addr == ADDR_CNT_LO) begin
        s_nxt.rdata = s_r.cnt[7:0];
      end else if (bus.addr == ADDR_CNT_HI) begin
        s_nxt.rdata = s_r.cnt[15:8];
      end else if (in_window(bus.addr, ADDR_MMODE_BASE, 8'(NUM_MODULES))) begin
        s_nxt.rdata = s_r.mmode[mode_idx(bus.addr)];
      end else if (in_window(bus.addr, ADDR_CMP_BASE, 8'(2 * NUM_MODULES))) begin
        s_nxt.rdata = bus.addr[0] ? s_r.cmp[cmp_idx(bus.addr)][15:8]
                                  : s_r.cmp[cmp_idx(bus.addr)][7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // reset leaves the watchdog armed with a divide-by-12 clock and zero offset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.cnt <= CNT_RESET;
      s_r.cf <= CTRL_RESET[CTRL_CF];
      s_r.cr <= CTRL_RESET[CTRL_CR];
      s_r.wdog_enable_bit <= WDOG_ENABLE_BIT_RESET;
      s_r.lock <= LOCK_RESET;
      s_r.cps <= CS_DIV12;
      s_r.mmode <= {NUM_MODULES{MMODE_RESET}};
      s_r.cmp <= {NUM_MODULES{CMP_RESET}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign wdog_reset_req = s_r.wdrst;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence force_write;
    wd_en && bus.wr && bus.addr == ADDR_CTRL && bus.wdata[WDOG_MODULE];
  endsequence

  sequence deadline_hit;
    wd_en && cnt_info.tick && s_r.cnt[7:0] == 8'hff &&
      s_r.cmp[WDOG_MODULE][15:8] == s_r.cnt[15:8];
  endsequence

  sequence update_write;
    wd_en && bus.wr && bus.addr == ADDR_CMP_BASE + 8'h05;
  endsequence

  wdog_pulse_a: assert property (wdog_reset_req |=> !wdog_reset_req)
    else $error("watchdog reset request longer than one cycle");
  force_reset_a: assert property (force_write |=> wdog_reset_req)
    else $error("forced watchdog reset missing");
  deadline_reset_a: assert property (deadline_hit |=> wdog_reset_req)
    else $error("watchdog deadline reset missing");
  update_load_a: assert property (update_write |=>
    s_r.cmp[WDOG_MODULE][15:8] == $past(upd_calc))
    else $error("update byte not loaded with counter high plus offset");
  cnt_locked_a: assert property (wd_en && bus.wr && bus.addr == ADDR_CNT_HI && !cnt_info.tick
    |=> $stable(s_r.cnt))
    else $error("counter changed by write while watchdog enabled");
  wd_runs_a: assert property (wd_en && !s_r.cr && tick && !(s_r.idle && cpu_idle) && !bus.wr
    |=> s_r.cnt == 16'($past(s_r.cnt) + 16'h0001))
    else $error("counter not forced on by watchdog");
  cf_wrap_a: assert property (cnt_info.tick && cnt_info.wrap |=> s_r.cf)
    else $error("overflow flag not set on wrap");
  cmp_enable_a: assert property (bus.wr && bus.addr == ADDR_CMP_BASE
    |=> !s_r.mmode[0][MM_CMPEN])
    else $error("compare enable not cleared by low byte write");
  lock_hold_a: assert property (s_r.lock |=> s_r.lock && wd_en)
    else $error("watchdog lock released before reset");
  idle_hold_a: assert property (s_r.idle && cpu_idle && !bus.wr |=> $stable(s_r.cnt))
    else $error("counter moved while suspended in idle");

endmodule : pcw_array

// ### dv/pcw_tb.sv
// self-checking bench for the counter array pwm16 / watchdog core
`timescale 1ns/1ps
module tb import pcw_pkg::*; ;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] exp;
  } pcw_row_type;

  localparam pcw_row_type ROWS [12] = '{
    '{ADDR_CTRL, 8'h00}, '{ADDR_MODE, 8'h40}, '{ADDR_MMODE_BASE, 8'h00},
    '{ADDR_MMODE_BASE + 8'h01, 8'h00}, '{ADDR_MMODE_BASE + 8'h02, 8'h00},
    '{ADDR_CMP_BASE, 8'h00}, '{ADDR_CMP_BASE + 8'h01, 8'h00},
    '{ADDR_CMP_BASE + 8'h02, 8'h00}, '{ADDR_CMP_BASE + 8'h03, 8'h00},
    '{ADDR_CMP_BASE + 8'h04, 8'h00}, '{8'h07, 8'h00}, '{8'h0e, 8'h00}
  };
  localparam logic [7:0] CMP2_LO = ADDR_CMP_BASE + 8'h04;
  localparam logic [7:0] CMP2_HI = ADDR_CMP_BASE + 8'h05;

  logic core_clk;
  logic nrst;
  pcw_bus_req_type bus;
  logic [7:0] rdata;
  logic cpu_idle;
  logic [NUM_MODULES-1:0] module_output_pin;
  logic wdog_reset_req;
  int cyc;
  int fails;
  int num_checks;
  int rel;
  int n;
  int i;
  logic [7:0] a;
  logic [7:0] b;

  // timer and external sources stay idle: every scenario runs on /12 or the core clock
  pcw_array uut (
    .core_clk(core_clk),
    .nrst(nrst),
    .bus(bus),
    .rdata(rdata),
    .cpu_idle(cpu_idle),
    .tmr0_ovf(1'b0),
    .ext_osc_tick(1'b0),
    .ext_clk_pin(1'b0),
    .module_output_pin(module_output_pin),
    .wdog_reset_req(wdog_reset_req)
  );

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  task automatic chk_cnt(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_cnt

  // one idle cycle between strobes keeps each signal to one assignment per edge
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{rd: 1'b0, wr: 1'b1, addr: ad, wdata: d};
    @(posedge core_clk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge core_clk);
    bus <= '{rd: 1'b1, wr: 1'b0, addr: ad, wdata: 8'h00};
    @(posedge core_clk);
    bus <= '0;
    #1 d = rdata;
  endtask : rd

  task automatic rdchk(input logic [7:0] ad, input logic [7:0] e);
    logic [7:0] d;
    rd(ad, d);
    chk8(d, e);
  endtask : rdchk

  task automatic wait_pulse(input int max, output int cnt);
    int k;
    cnt = -1;
    // look before the first edge: a forced pulse already stands when the write task returns
    for (k = 0; k < max; k++) begin
      #1;
      if (wdog_reset_req === 1'b1) begin
        cnt = k;
        break;
      end
      @(posedge core_clk);
    end
    if (cnt >= 0) begin
      @(posedge core_clk);
      #1 chk1(wdog_reset_req, 1'b0);
    end
  endtask : wait_pulse

  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc = 0;
    fails = 0;
    num_checks = 0;
    nrst = 1'b0;
    bus = '0;
    cpu_idle = 1'b0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    rel = cyc;
    for (i = 0; i < 12; i++) begin
      rdchk(ROWS[i].addr, ROWS[i].exp);
    end
    // untouched watchdog times out after 256 ticks of core/12
    wait_pulse(4000, n);
    chk_cnt(cyc - rel, 3060, 3090);
    // disable, core clock source, pwm16 on module 0 near the wrap
    // clock select is frozen while the watchdog is on, so disable first
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_MODE, 8'h08);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CNT_LO, 8'hf0);
    wr(ADDR_CNT_HI, 8'hff);
    rdchk(ADDR_CNT_LO, 8'hf0);
    wr(ADDR_MMODE_BASE, 8'hca);
    wr(ADDR_CMP_BASE, 8'hf8);
    rdchk(ADDR_MMODE_BASE, 8'h8a);
    chk1(module_output_pin[0], 1'b0);
    wr(ADDR_CMP_BASE + 8'h01, 8'hff);
    rdchk(ADDR_MMODE_BASE, 8'hca);
    wr(ADDR_CTRL, 8'h40);
    n = 0;
    while (module_output_pin[0] !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    n = 0;
    while (module_output_pin[0] === 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk_cnt(n, 8, 8);
    rdchk(ADDR_CTRL, 8'hc1);
    // zero compare: match beats the wrap, output stays high
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CMP_BASE, 8'h00);
    wr(ADDR_CMP_BASE + 8'h01, 8'h00);
    wr(ADDR_CNT_LO, 8'hfc);
    wr(ADDR_CNT_HI, 8'hff);
    wr(ADDR_CTRL, 8'h40);
    repeat (10) @(posedge core_clk);
    #1 chk1(module_output_pin[0], 1'b1);
    // idle suspension freezes the counter
    wr(ADDR_MODE, 8'h88);
    @(posedge core_clk);
    cpu_idle <= 1'b1;
    rd(ADDR_CNT_LO, a);
    repeat (10) @(posedge core_clk);
    rd(ADDR_CNT_LO, b);
    chk8(b, a);
    @(posedge core_clk);
    cpu_idle <= 1'b0;
    rd(ADDR_CNT_LO, b);
    chk1(b != a, 1'b1);
    // configure the watchdog in the documented order, then update
    wr(ADDR_MODE, 8'h08);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CNT_HI, 8'h00);
    wr(CMP2_LO, 8'h01);
    wr(ADDR_MODE, 8'h48);
    wr(CMP2_HI, 8'h77);
    rel = cyc;
    wr(ADDR_CNT_HI, 8'h55);
    wr(ADDR_MODE, 8'hc2);
    rdchk(ADDR_MODE, 8'h48);
    rdchk(ADDR_CNT_HI, 8'h00);
    rd(ADDR_CTRL, a);
    chk8(a & 8'h40, 8'h00);
    rdchk(CMP2_HI, 8'h01);
    wait_pulse(700, n);
    chk_cnt(cyc - rel, 505, 515);
    // software-forced reset, then lock holds the enable
    wr(ADDR_CTRL, 8'h04);
    wait_pulse(3, n);
    chk1(n >= 0, 1'b1);
    wr(ADDR_MODE, 8'h28);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'h04);
    wait_pulse(3, n);
    chk1(n >= 0, 1'b1);
    wr(ADDR_MODE, 8'h08);
    rdchk(ADDR_MODE, 8'h28);
    // a second reset in mid-run releases the lock
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (16) @(posedge core_clk);
    #1 chk1(module_output_pin[0], 1'b0);
    chk1(wdog_reset_req, 1'b0);
    @(posedge core_clk);
    nrst <= 1'b1;
    rdchk(ADDR_MODE, 8'h40);
    tally_and_finish();
  end
endmodule : tb
